// file: rtl/axrf_pkg.sv
// Purpose: shared constants for the axis ramp and feed-forward block
// Assumes: 10 MHz pclk, four axes, APB register access
// Notes: offsets are byte addresses of aligned 32-bit words
package axrf_pkg;
  // sizes
  localparam int AXES = 4;
  localparam int FEED_W = 16;
  localparam int ERR_W = 16;
  localparam int CMD_W = 35;
  localparam int ADDR_W = 8;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CTRL_PERIOD_MS = 10;
  localparam int CTRL_PERIOD_CYC = CLK_HZ / 1000 * CTRL_PERIOD_MS;
  localparam int LIN_UNIT_MS = 20;
  localparam int BELL_UNIT_MS = 10;
  localparam logic [8:0] LIN_TICKS = 9'(LIN_UNIT_MS / CTRL_PERIOD_MS);
  localparam logic [8:0] BELL_TICKS = 9'(BELL_UNIT_MS / CTRL_PERIOD_MS);
  // feed-forward arithmetic
  localparam logic [23:0] FF_DIVISOR = 24'h000006;
  localparam int BELL_FF_SHIFT = 3;
  localparam logic [4:0] DIV_LAST_CNT = 5'h0F;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RAMP = 8'h04;
  localparam logic [7:0] OFF_FFG = 8'h08;
  localparam logic [7:0] OFF_BELL = 8'h0C;
  localparam logic [7:0] OFF_K1 = 8'h10;
  localparam logic [7:0] OFF_K2 = 8'h14;
  localparam logic [7:0] OFF_KNEE01 = 8'h18;
  localparam logic [7:0] OFF_KNEE23 = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // control bits
  localparam int CTRL_ALL_LIN = 0;
  localparam int CTRL_CORNER_OFF = 1;
  localparam int CTRL_BELL_EN = 2;
  // move types
  localparam logic [1:0] MV_RAPID = 2'h0;
  localparam logic [1:0] MV_LINEAR = 2'h1;
  localparam logic [1:0] MV_ARC = 2'h2;
  // ramp kinds
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_LIN = 2'h1;
  localparam logic [1:0] KIND_BELL = 2'h2;
  // profile states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CALC = 5'h02,
    ST_ACCEL = 5'h04,
    ST_CRUISE = 5'h08,
    ST_DECEL = 5'h10
  } axrf_state_t;
endpackage

// file: rtl/axrf_div.sv
// Purpose: serial divider giving the per-period velocity increment
// Assumes: divisor nonzero whenever start is pulsed
// Notes: answer arrives seventeen cycles after start
`timescale 1ns/1ns
`default_nettype none
module axrf_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic [15:0] dividend,
  input wire logic [8:0] divisor,
  // answer
  output logic done,
  output logic [15:0] quotient
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [9:0] rem;
    logic [15:0] quo;
    logic [8:0] dvs;
  } axrf_div_st_t;

  axrf_div_st_t st_ff;
  axrf_div_st_t nxt_st;
  logic [9:0] r;

  // one restoring step per cycle
  always_comb begin
    nxt_st = st_ff;
    r = '0;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = '0;
      nxt_st.rem = '0;
      nxt_st.quo = dividend;
      nxt_st.dvs = divisor;
    end else if (st_ff.busy) begin
      r = {st_ff.rem[8:0], st_ff.quo[15]};
      nxt_st.quo = {st_ff.quo[14:0], 1'b0};
      if (r >= {1'b0, st_ff.dvs}) begin
        nxt_st.rem = r - {1'b0, st_ff.dvs};
        nxt_st.quo[0] = 1'b1;
      end else begin
        nxt_st.rem = r;
      end
      nxt_st.cnt = st_ff.cnt + 5'h01;
      if (st_ff.cnt == axrf_pkg::DIV_LAST_CNT) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign quotient = st_ff.quo;
endmodule
`default_nettype wire

// file: rtl/axrf_top.sv
// Purpose: ramp profiling, feed-forward and two-slope gain for four axes
// Assumes: move and error inputs come from logic on pclk
// Notes: APB slave with one wait state on every access
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1: each axis keeps an 8-bit linear ramp time, 20 ms per count
// R2: a zero ramp time gives that axis no linear ramp
// R3: ramp reaches the target feed in the set time; braking takes as long
// R4: coordinated rapid or straight moves use the longest participating ramp time
// R5: arcs never get linear ramps
// R6: select bit clear ramps straight moves only at maximum feed; set ramps all
// R7: corner-rounding off bit set suppresses ramps in corner-rounding blocks
// R8: bell enable set applies bell ramps to all move types and feeds
// R9: one shared 8-bit bell time, 10 ms per count, zero means none
// R10: bell time only acts while the bell enable bit is set
// R11: each axis keeps an 8-bit feed-forward gain for either ramp type
// R12: feed-forward term is coefficient times programmed feed over six
// R13: coefficient is the gain when linear, one eighth when bell-shaped
// R14: below the knee the command is low gain times the sum
// R15: above the knee add high gain times the excess over the knee
// R16: software should enable feed-forward only together with ramps
// R17: linear ramp velocity changes by equal steps each control period
module axrf_top #(
  parameter int CTRL_PERIOD_CYC = axrf_pkg::CTRL_PERIOD_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [axrf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // move requests
  input wire logic move_start,
  input wire logic move_stop,
  input wire logic [1:0] move_type,
  input wire logic corner_rounding_code,
  input wire logic [axrf_pkg::AXES-1:0] move_axes,
  input wire logic [axrf_pkg::FEED_W-1:0] move_feed,
  // following error per axis
  input wire logic [axrf_pkg::AXES-1:0][axrf_pkg::ERR_W-1:0] follow_err,
  // servo commands and profile state
  output logic [axrf_pkg::AXES-1:0][axrf_pkg::CMD_W-1:0] drive_cmd,
  output logic [axrf_pkg::FEED_W-1:0] prof_feed,
  output logic prof_busy
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] ctrl;
    logic [3:0][7:0] ramp_time;
    logic [3:0][7:0] ff_gain;
    logic [3:0][7:0] k1;
    logic [3:0][7:0] k2;
    logic [7:0] bell_time;
    logic [15:0] max_feed;
    logic [3:0][15:0] knee;
    axrf_pkg::axrf_state_t st;
    logic [1:0] kind;
    logic [8:0] steps;
    logic [8:0] count;
    logic [15:0] vel;
    logic [15:0] target;
    logic [15:0] inc;
    logic [16:0] tick_cnt;
    logic tick;
    logic div_start;
    logic stop_pend;
    logic busy;
    logic [3:0][34:0] cmd;
  } axrf_top_st_t;

  axrf_top_st_t st_ff;
  axrf_top_st_t nxt_st;
  logic hit;
  logic [31:0] rd_val;
  logic use_bell;
  logic lin_ok;
  logic [7:0] max_rt;
  logic [1:0] start_kind;
  logic [8:0] start_steps;
  logic [15:0] feed_now;
  logic div_done;
  logic [15:0] div_q;
  logic [3:0][34:0] cmd_nxt;

  // longest ramp time among the axes taking part
  function automatic logic [7:0] axrf_max_time(input logic [3:0][7:0] t,
                                               input logic [3:0] m);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < axrf_pkg::AXES; i++) begin
      if (m[i] && (t[i] > r)) begin
        r = t[i];
      end
    end
    return r;
  endfunction

  // ramp choice for a new move
  assign max_rt = axrf_max_time(st_ff.ramp_time, move_axes); // R4
  assign use_bell = st_ff.ctrl[axrf_pkg::CTRL_BELL_EN] && (st_ff.bell_time != '0); // R8 R10
  assign lin_ok = (max_rt != '0) // R2
    && (move_type != axrf_pkg::MV_ARC) // R5
    && !(corner_rounding_code && st_ff.ctrl[axrf_pkg::CTRL_CORNER_OFF]) // R7
    && ((move_type == axrf_pkg::MV_RAPID) || (st_ff.ctrl[axrf_pkg::CTRL_ALL_LIN])
        || (move_feed == st_ff.max_feed)); // R6
  assign start_kind = use_bell ? axrf_pkg::KIND_BELL :
                      (lin_ok ? axrf_pkg::KIND_LIN : axrf_pkg::KIND_NONE);
  assign start_steps = use_bell ? 9'(st_ff.bell_time) * axrf_pkg::BELL_TICKS : // R9
                       9'(max_rt) * axrf_pkg::LIN_TICKS; // R1
  assign feed_now = st_ff.busy ? st_ff.target : '0;

  // increment divider
  axrf_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(st_ff.div_start),
    .dividend(st_ff.target),
    .divisor(st_ff.steps),
    .done(div_done),
    .quotient(div_q)
  );

  // feed-forward and two-slope gain per axis
  for (genvar a = 0; a < axrf_pkg::AXES; a++) begin : g_axis
    logic [7:0] coef;
    logic [23:0] ffv;
    logic signed [25:0] sum;
    logic [24:0] mag;
    logic [33:0] lo;
    logic [33:0] hi;
    logic [33:0] amp;
    assign coef = (st_ff.kind == axrf_pkg::KIND_BELL) ? // R11 R13
                  (st_ff.ff_gain[a] >> axrf_pkg::BELL_FF_SHIFT) : st_ff.ff_gain[a];
    assign ffv = ({16'h0000, coef} * {8'h00, feed_now}) / axrf_pkg::FF_DIVISOR; // R12
    assign sum = $signed({{10{follow_err[a][15]}}, follow_err[a]})
               + $signed({2'b00, ffv});
    assign mag = sum[25] ? 25'(-sum) : sum[24:0];
    assign lo = {26'h0000000, st_ff.k1[a]} * {9'h000, mag}; // R14
    assign hi = ({26'h0000000, st_ff.k1[a]} * {18'h00000, st_ff.knee[a]})
              + ({26'h0000000, st_ff.k2[a]} * {9'h000, 25'(mag - {9'h000, st_ff.knee[a]})}); // R15
    assign amp = (mag < {9'h000, st_ff.knee[a]}) ? lo : hi; // R14 R15
    assign cmd_nxt[a] = sum[25] ? 35'(-{1'b0, amp}) : {1'b0, amp};
  end

  // next-state logic: bus, control period, profile
  always_comb begin
    nxt_st = st_ff;
    hit = 1'b1;
    rd_val = '0;
    nxt_st.tick = 1'b0;
    nxt_st.div_start = 1'b0;
    if (st_ff.tick_cnt == 17'(CTRL_PERIOD_CYC - 1)) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 17'h00001;
    end
    case (paddr)
      axrf_pkg::OFF_CTRL: rd_val = {29'h00000000, st_ff.ctrl};
      axrf_pkg::OFF_RAMP: rd_val = st_ff.ramp_time;
      axrf_pkg::OFF_FFG: rd_val = st_ff.ff_gain;
      axrf_pkg::OFF_BELL: rd_val = {st_ff.max_feed, 8'h00, st_ff.bell_time};
      axrf_pkg::OFF_K1: rd_val = st_ff.k1;
      axrf_pkg::OFF_K2: rd_val = st_ff.k2;
      axrf_pkg::OFF_KNEE01: rd_val = st_ff.knee[1:0];
      axrf_pkg::OFF_KNEE23: rd_val = st_ff.knee[3:2];
      axrf_pkg::OFF_STATUS: rd_val = {st_ff.vel, 13'h0000, st_ff.kind, st_ff.busy};
      default: hit = 1'b0;
    endcase
    // answer in the second access cycle
    if (psel && penable && !st_ff.pready) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = !hit;
      nxt_st.prdata = (pwrite || !hit) ? '0 : rd_val;
    end else begin
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
    end
    // writes land at the completing edge
    if (psel && penable && pwrite && st_ff.pready && hit) begin
      case (paddr)
        axrf_pkg::OFF_CTRL: nxt_st.ctrl = pwdata[2:0];
        axrf_pkg::OFF_RAMP: nxt_st.ramp_time = pwdata;
        axrf_pkg::OFF_FFG: nxt_st.ff_gain = pwdata;
        axrf_pkg::OFF_BELL: begin
          nxt_st.bell_time = pwdata[7:0];
          nxt_st.max_feed = pwdata[31:16];
        end
        axrf_pkg::OFF_K1: nxt_st.k1 = pwdata;
        axrf_pkg::OFF_K2: nxt_st.k2 = pwdata;
        axrf_pkg::OFF_KNEE01: nxt_st.knee[1:0] = pwdata;
        axrf_pkg::OFF_KNEE23: nxt_st.knee[3:2] = pwdata;
        default: ;
      endcase
    end
    // velocity profile
    case (st_ff.st)
      axrf_pkg::ST_IDLE: begin
        if (move_start) begin
          nxt_st.target = move_feed;
          nxt_st.kind = start_kind;
          nxt_st.steps = start_steps;
          nxt_st.count = '0;
          nxt_st.stop_pend = 1'b0;
          if (start_kind == axrf_pkg::KIND_NONE) begin
            nxt_st.vel = move_feed; // R2 R5
            nxt_st.st = axrf_pkg::ST_CRUISE;
          end else begin
            nxt_st.vel = '0;
            nxt_st.div_start = 1'b1;
            nxt_st.st = axrf_pkg::ST_CALC;
          end
        end
      end
      axrf_pkg::ST_CALC: begin
        if (move_stop) begin
          nxt_st.stop_pend = 1'b1;
        end
        if (div_done) begin
          nxt_st.inc = div_q; // R17
          nxt_st.st = axrf_pkg::ST_ACCEL;
        end
      end
      axrf_pkg::ST_ACCEL: begin
        if (move_stop || st_ff.stop_pend) begin
          nxt_st.stop_pend = 1'b0;
          nxt_st.st = axrf_pkg::ST_DECEL;
        end else if (st_ff.tick) begin
          if ((st_ff.count + 9'h001) == st_ff.steps) begin
            nxt_st.vel = st_ff.target; // R3
            nxt_st.count = st_ff.steps;
            nxt_st.st = axrf_pkg::ST_CRUISE;
          end else begin
            nxt_st.vel = st_ff.vel + st_ff.inc; // R17
            nxt_st.count = st_ff.count + 9'h001;
          end
        end
      end
      axrf_pkg::ST_CRUISE: begin
        if (move_stop) begin
          if (st_ff.kind == axrf_pkg::KIND_NONE) begin
            nxt_st.vel = '0;
            nxt_st.st = axrf_pkg::ST_IDLE;
          end else begin
            nxt_st.st = axrf_pkg::ST_DECEL;
          end
        end
      end
      axrf_pkg::ST_DECEL: begin
        if (st_ff.tick) begin
          if (st_ff.count <= 9'h001) begin
            nxt_st.vel = '0; // R3
            nxt_st.count = '0;
            nxt_st.st = axrf_pkg::ST_IDLE;
          end else begin
            nxt_st.vel = (st_ff.vel > st_ff.inc) ? st_ff.vel - st_ff.inc : '0; // R3 R17
            nxt_st.count = st_ff.count - 9'h001;
          end
        end
      end
      default: nxt_st.st = axrf_pkg::ST_IDLE;
    endcase
    nxt_st.busy = (nxt_st.st != axrf_pkg::ST_IDLE);
    nxt_st.cmd = cmd_nxt;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.st <= axrf_pkg::ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign drive_cmd = st_ff.cmd;
  assign prof_feed = st_ff.vel;
  assign prof_busy = st_ff.busy;

  // checks on the profile and command path
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic start_go;
  assign start_go = (st_ff.st == axrf_pkg::ST_IDLE) && move_start;

  sequence s_up_mid;
    st_ff.st == axrf_pkg::ST_ACCEL && st_ff.tick && !move_stop && !st_ff.stop_pend
      && (st_ff.count + 9'h001) != st_ff.steps;
  endsequence
  sequence s_up_last;
    st_ff.st == axrf_pkg::ST_ACCEL && st_ff.tick && !move_stop && !st_ff.stop_pend
      && (st_ff.count + 9'h001) == st_ff.steps;
  endsequence

  property p_lin_steps;
    start_go && !use_bell && lin_ok |=>
      st_ff.kind == axrf_pkg::KIND_LIN && st_ff.steps == 9'($past(max_rt)) * axrf_pkg::LIN_TICKS;
  endproperty
  a_lin_steps: assert property (p_lin_steps) else $error("linear ramp length wrong"); // R1 R4

  property p_zero_time;
    start_go && !use_bell && max_rt == '0 |=>
      st_ff.kind == axrf_pkg::KIND_NONE && st_ff.vel == $past(move_feed);
  endproperty
  a_zero_time: assert property (p_zero_time) else $error("ramp with zero time"); // R2

  property p_reach;
    s_up_last |=> st_ff.vel == st_ff.target && st_ff.st == axrf_pkg::ST_CRUISE;
  endproperty
  a_reach: assert property (p_reach) else $error("target not reached at ramp end"); // R3

  property p_brake;
    st_ff.st == axrf_pkg::ST_DECEL && st_ff.tick && st_ff.count > 9'h001 |=>
      st_ff.count == $past(st_ff.count) - 9'h001 && st_ff.st == axrf_pkg::ST_DECEL;
  endproperty
  a_brake: assert property (p_brake) else $error("braking step count wrong"); // R3

  property p_arc;
    start_go && move_type == axrf_pkg::MV_ARC && !use_bell |=>
      st_ff.kind == axrf_pkg::KIND_NONE;
  endproperty
  a_arc: assert property (p_arc) else $error("arc got a linear ramp"); // R5

  property p_feed_sel;
    start_go && move_type == axrf_pkg::MV_LINEAR && !use_bell
      && !st_ff.ctrl[axrf_pkg::CTRL_ALL_LIN] && move_feed != st_ff.max_feed |=>
      st_ff.kind == axrf_pkg::KIND_NONE;
  endproperty
  a_feed_sel: assert property (p_feed_sel) else $error("ramp below maximum feed"); // R6

  property p_corner;
    start_go && corner_rounding_code && st_ff.ctrl[axrf_pkg::CTRL_CORNER_OFF] && !use_bell
      |=> st_ff.kind == axrf_pkg::KIND_NONE;
  endproperty
  a_corner: assert property (p_corner) else $error("ramp in corner block"); // R7

  property p_bell;
    start_go && use_bell |=> st_ff.kind == axrf_pkg::KIND_BELL
      && st_ff.steps == 9'($past(st_ff.bell_time)) * axrf_pkg::BELL_TICKS;
  endproperty
  a_bell: assert property (p_bell) else $error("bell ramp not applied"); // R8 R9

  property p_bell_off;
    start_go && !st_ff.ctrl[axrf_pkg::CTRL_BELL_EN] |=> st_ff.kind != axrf_pkg::KIND_BELL;
  endproperty
  a_bell_off: assert property (p_bell_off) else $error("bell ramp while disabled"); // R10

  property p_idle_ff;
    !st_ff.busy && follow_err[0] == '0 |=> drive_cmd[0] == '0;
  endproperty
  a_idle_ff: assert property (p_idle_ff) else $error("feed-forward while idle"); // R12

  property p_equal_step;
    s_up_mid |=> st_ff.vel == $past(st_ff.vel) + $past(st_ff.inc);
  endproperty
  a_equal_step: assert property (p_equal_step) else $error("unequal ramp step"); // R17
endmodule
`default_nettype wire

// file: test/axrf_servo_model.sv
// Purpose: servo drive stand-in on the analog command outputs
// Assumes: the bench chooses the drive lag seen as following error
// Notes: lag returns with no delay so command latency stays one cycle
`timescale 1ns/1ns
`default_nettype none
module axrf_servo_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // analog side
  input wire logic [axrf_pkg::AXES-1:0][axrf_pkg::CMD_W-1:0] drive_cmd,
  input wire logic [axrf_pkg::AXES-1:0][axrf_pkg::ERR_W-1:0] lag,
  output logic [axrf_pkg::AXES-1:0][axrf_pkg::ERR_W-1:0] follow_err,
  output logic [axrf_pkg::AXES-1:0][axrf_pkg::CMD_W-1:0] applied_ff
);
  // lag seen by the position loop
  assign follow_err = lag;
  // drive samples its analog input each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) applied_ff <= '0;
    else applied_ff <= drive_cmd;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench for the axis ramp and feed-forward block
// Assumes: control period shortened to 20 cycles
// Notes: expectations go to queues, monitors compare as results appear
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct {int at; int ax; logic [34:0] v;} axrf_tb_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic move_start, move_stop, corner_rounding_code, prof_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] move_type;
  logic [3:0] move_axes;
  logic [15:0] move_feed, prof_feed, pf_prev;
  logic [3:0][15:0] lag, follow_err;
  logic [3:0][34:0] drive_cmd;
  logic [32:0] rd_q[$];
  logic [15:0] fd_q[$];
  axrf_tb_note_t cm_q[$];
  axrf_tb_note_t nt_c;
  int fails, total_checks, seed, cyc, i, bell;
  int k1[4], k2[4], kn[4], ffg[4];
  // design and drive model
  axrf_top #(.CTRL_PERIOD_CYC(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .move_start(move_start), .move_stop(move_stop),
    .move_type(move_type), .corner_rounding_code(corner_rounding_code),
    .move_axes(move_axes), .move_feed(move_feed), .follow_err(follow_err),
    .drive_cmd(drive_cmd), .prof_feed(prof_feed), .prof_busy(prof_busy));
  axrf_servo_model drv (.pclk(pclk), .presetn(presetn), .drive_cmd(drive_cmd), .lag(lag),
    .follow_err(follow_err), .applied_ff());
  // expected analog command from error and feed
  function automatic logic [34:0] cmd_of(int a, int err, int feed);
    int s, m, c;
    c = bell ? ffg[a] >> 3 : ffg[a];
    s = err + c * feed / 6;
    m = s < 0 ? -s : s;
    m = m < kn[a] ? k1[a] * m : k1[a] * kn[a] + k2[a] * (m - kn[a]);
    return 35'(s < 0 ? -m : m);
  endfunction
  function automatic logic [15:0] rnd();
    return 16'(12 * ($unsigned($random(seed)) % 900 + 1));
  endfunction
  function automatic logic [31:0] pk(int q[4]);
    return {8'(q[3]), 8'(q[2]), 8'(q[1]), 8'(q[0])};
  endfunction
  task automatic chk(logic [34:0] got, logic [34:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (fd_q.size() + cm_q.size() + rd_q.size() != 0) fails++;
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rd_q.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      close_out();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d);
    apb(1'b0, a, d, {1'b0, d});
  endtask
  task automatic hold(logic w, logic [15:0] f);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(w ? prof_busy === 1'b0 : prof_feed === f) && n < 3000);
    if (n >= 3000) begin
      fails++;
      close_out();
    end
  endtask
  // random lag on every axis, expectation one cycle later
  task automatic probe(int f, int na);
    logic [31:0] r;
    axrf_tb_note_t nt;
    @(posedge pclk);
    for (int a = 0; a < 4; a++) begin
      r = $random(seed);
      lag[a] <= {{5{r[10]}}, r[10:0]};
      nt.at = cyc + 2;
      nt.ax = a;
      nt.v = cmd_of(a, $signed(r[10:0]), f);
      if (a < na) cm_q.push_back(nt);
    end
  endtask
  // one move with n equal steps up and down, n zero for a jump
  task automatic move(logic [1:0] t, logic c, logic [3:0] ax, logic [15:0] f, int n, int pr);
    for (int k = 1; k <= n; k++) fd_q.push_back(16'(k == n ? f : f / n * k));
    if (n == 0) fd_q.push_back(f);
    for (int k = 1; k <= n; k++) fd_q.push_back(16'(k == n ? 16'h0 : f - f / n * k));
    if (n == 0) fd_q.push_back(16'h0);
    @(posedge pclk);
    move_type <= t;
    corner_rounding_code <= c;
    move_axes <= ax;
    move_feed <= f;
    move_start <= 1'b1;
    @(posedge pclk);
    move_start <= 1'b0;
    hold(1'b0, f);
    if (pr != 0) probe(f, 1);
    @(posedge pclk);
    move_stop <= 1'b1;
    @(posedge pclk);
    move_stop <= 1'b0;
    hold(1'b1, 16'h0);
  endtask
  // clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // cycle count and result monitors
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready === 1'b1) begin
      chk({2'b0, pslverr, prdata}, {2'b0, rd_q.pop_front()});
    end
    // no feed tracking while reset may still leave the profile unknown
    if (presetn && prof_feed !== pf_prev) begin
      chk(35'(prof_feed), fd_q.size() ? 35'(fd_q.pop_front()) : ~35'(prof_feed));
    end
    pf_prev <= prof_feed;
  end
  // oldest command note against the settled command
  always @(negedge pclk) begin
    while (cm_q.size() != 0 && cm_q[0].at <= cyc) begin
      nt_c = cm_q.pop_front();
      chk(drive_cmd[nt_c.ax], nt_c.v);
    end
  end
  // main sequence
  initial begin
    seed = 45755;
    {psel, penable, pwrite, paddr, pwdata, move_start, move_stop} = '0;
    {move_type, corner_rounding_code, move_axes, move_feed, lag, pf_prev} = '0;
    {fails, total_checks, cyc, bell} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(axrf_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, 8'h24, 32'h5, {1'b1, 32'h0});
    apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
    wr(axrf_pkg::OFF_STATUS, 32'hFFFFFFFF);
    rd(axrf_pkg::OFF_STATUS, 32'h0);
    for (i = 0; i < 4; i++) begin
      k1[i] = $random(seed) & 32'hFF;
      k2[i] = $random(seed) & 32'hFF;
      kn[i] = $random(seed) & 32'h3FF;
      ffg[i] = $random(seed) & 32'hFF;
    end
    ffg[2] = 0;
    wr(axrf_pkg::OFF_RAMP, 32'h03000201);
    rd(axrf_pkg::OFF_RAMP, 32'h03000201);
    wr(axrf_pkg::OFF_FFG, pk(ffg));
    rd(axrf_pkg::OFF_FFG, pk(ffg));
    wr(axrf_pkg::OFF_K1, pk(k1));
    wr(axrf_pkg::OFF_K2, pk(k2));
    wr(axrf_pkg::OFF_KNEE01, {16'(kn[1]), 16'(kn[0])});
    wr(axrf_pkg::OFF_KNEE23, {16'(kn[3]), 16'(kn[2])});
    wr(axrf_pkg::OFF_BELL, 32'h2EE00002);
    wr(axrf_pkg::OFF_CTRL, 32'h1);
    repeat (4) probe(0, 4);
    move(axrf_pkg::MV_LINEAR, 1'b0, 4'h3, rnd(), axrf_pkg::LIN_TICKS * 2, 1);
    move(axrf_pkg::MV_RAPID, 1'b1, 4'h1, rnd(), axrf_pkg::LIN_TICKS, 0);
    move(axrf_pkg::MV_ARC, 1'b0, 4'h3, rnd(), 0, 0);
    move(axrf_pkg::MV_RAPID, 1'b0, 4'h4, rnd(), 0, 0);
    wr(axrf_pkg::OFF_CTRL, 32'h0);
    move(axrf_pkg::MV_LINEAR, 1'b0, 4'h3, rnd(), 0, 0);
    move(axrf_pkg::MV_LINEAR, 1'b0, 4'h3, 16'h2EE0, axrf_pkg::LIN_TICKS * 2, 0);
    wr(axrf_pkg::OFF_CTRL, 32'h3);
    move(axrf_pkg::MV_RAPID, 1'b1, 4'h1, rnd(), 0, 0);
    wr(axrf_pkg::OFF_CTRL, 32'h4);
    bell = 1;
    move(axrf_pkg::MV_ARC, 1'b0, 4'h1, rnd(), axrf_pkg::BELL_TICKS * 2, 1);
    wr(axrf_pkg::OFF_BELL, 32'h2EE00000);
    move(axrf_pkg::MV_ARC, 1'b0, 4'h1, rnd(), 0, 0);
    repeat (4) @(posedge pclk);
    close_out();
  end
endmodule
`default_nettype wire
